// >>> bench/tb.sv
// Self-checking bench for the video output pin block.
// Assumes the capture model sits on the pins and one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vdop_pkg::*;
  logic              mclk_i, srst_i, rst_pin_n, addr_sel, soft_rst, out_en;
  logic              ce, irq_req, src_valid, src_ready, pix_oe_n, strb_oe_n;
  logic              hs, vs, fld, blk, pv, irq_o, irq_oe_n, irq_line;
  logic [3:0]        pol;        // {blank, field, vsync, hsync}, 1 = active high
  logic [WORD_W-1:0] w_q;        // Word offered to the source port
  logic [PIX_W-1:0]  pix_bus, pix_line;
  logic [6:0]        addr;
  logic [4:0]        strb_line;
  logic [7:0]        cap_cnt;
  int                error_cnt, num_checks;

  vdop_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .rst_pin_n_i(rst_pin_n),
    .bus_addr_select_i(addr_sel), .i2c_addr_o(addr), .soft_rst_i(soft_rst),
    .out_en_i(out_en), .hsync_pol_i(pol[0]), .vsync_pol_i(pol[1]), .field_pol_i(pol[2]),
    .blank_pol_i(pol[3]), .src_valid_i(src_valid), .src_ready_o(src_ready),
    .src_data_i(w_q[PIX_W-1:0]), .src_pix_i(w_q[WD_PIX]), .src_hsync_i(w_q[WD_HS]),
    .src_vsync_i(w_q[WD_VS]), .src_field_i(w_q[WD_FLD]), .src_hblank_i(w_q[WD_HB]),
    .src_vblank_i(w_q[WD_VB]), .irq_req_i(irq_req), .pixel_out_bus_o(pix_bus),
    .pixel_out_oe_n_o(pix_oe_n), .hsync_o(hs), .vsync_o(vs), .field_o(fld), .blank_o(blk),
    .pixel_valid_out_o(pv), .strobe_oe_n_o(strb_oe_n), .irq_out_o(irq_o),
    .irq_out_oe_n_o(irq_oe_n));

  vdop_cap_model u_cap (.mclk_i(mclk_i), .clr_i(srst_i), .pix_i(pix_bus),
    .pix_oe_n_i(pix_oe_n), .strb_i({blk, fld, vs, hs, pv}), .strb_oe_n_i(strb_oe_n),
    .irq_i(irq_o), .irq_oe_n_i(irq_oe_n), .pix_line_o(pix_line), .strb_line_o(strb_line),
    .irq_line_o(irq_line), .cap_cnt_o(cap_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock, never gated
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Pin levels expected for a word under a polarity setting
  function automatic logic [19:0] exp_cap(input logic [WORD_W-1:0] w, input logic [3:0] p);
    logic [3:0] raw;
    raw = {w[WD_HB] | w[WD_VB], w[WD_FLD], w[WD_VS], w[WD_HS]};
    return {raw ^ ~p, w[PIX_W-1:0]};
  endfunction

  // Hold the word until an edge that sees room; valid is left up
  task automatic push(input logic [WORD_W-1:0] w);
    int k;
    k = 0;
    src_valid <= 1'b1;
    w_q       <= w;
    @(negedge mclk_i);
    while (src_ready !== 1'b1 && k < 50) begin
      @(negedge mclk_i);
      k++;
    end
    check(src_ready, 1);
    @(posedge mclk_i);
  endtask

  task automatic wait_cnt(input logic [7:0] n);
    int k;
    k = 0;
    while (cap_cnt !== n && k < 40) begin
      @(negedge mclk_i);
      k++;
    end
    repeat (4) @(negedge mclk_i);
    check(cap_cnt, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_state();
    @(negedge mclk_i);
    check(pix_oe_n, 1);
    check(strb_oe_n, 1);
    check(strb_line, 5'h1f);
    check(addr, ADDR_SEL_LO);
    check(irq_line, 1);
  endtask

  task automatic t_strap_irq();
    @(posedge mclk_i);
    addr_sel <= 1'b1;
    irq_req  <= 1'b1;
    repeat (6) @(negedge mclk_i);
    check(addr, 7'h45);
    check(irq_oe_n, 0);
    check(irq_line, 0);
    @(posedge mclk_i);
    addr_sel <= 1'b0;
    irq_req  <= 1'b0;
    repeat (6) @(negedge mclk_i);
    check(addr, 7'h44);
    check(irq_line, 1);
  endtask

  // Fill while floating, get refused, then drain with a non-pixel word inside
  task automatic t_fill_drain();
    logic [WORD_W-1:0] w [0:3];
    w[0] = {6'b000011, 16'hffff};
    w[1] = {6'b010010, 16'hbeef};
    w[2] = {6'b001101, 16'ha5a5};
    w[3] = {6'b100001, 16'h0000};
    for (int i = 0; i < 4; i++) push(w[i]);
    src_valid <= 1'b0;
    repeat (3) @(negedge mclk_i);
    check(src_ready, 0);
    check(cap_cnt, 0);
    @(posedge mclk_i);
    src_valid <= 1'b1;
    w_q       <= {6'b000001, 16'h7777};
    repeat (3) @(negedge mclk_i);
    check(src_ready, 0);
    @(posedge mclk_i);
    src_valid <= 1'b0;
    out_en    <= 1'b1;
    wait_cnt(8'h03);
    check(pv, 0);
    check(u_cap.cap_mem[0], exp_cap(w[0], 4'hf));
    check(u_cap.cap_mem[1], exp_cap(w[2], 4'hf));
    check(u_cap.cap_mem[2], exp_cap(w[3], 4'hf));
  endtask

  task automatic t_polarity();
    pol <= 4'h0;
    push({6'b001011, 16'h8001});
    src_valid <= 1'b0;
    wait_cnt(8'h04);
    check(u_cap.cap_mem[3], {4'ha, 16'h8001});
    pol <= 4'hf;
  endtask

  // Three low samples must be ignored, four must reset
  task automatic t_rst_pin();
    int hi, k;
    hi = 0;
    k  = 0;
    @(posedge mclk_i);
    rst_pin_n <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_pin_n <= 1'b1;
    repeat (12) begin
      @(negedge mclk_i);
      if (pix_oe_n !== 1'b0) hi++;
    end
    check(hi, 0);
    @(posedge mclk_i);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_pin_n <= 1'b1;
    while (pix_oe_n !== 1'b1 && k < 12) begin
      @(negedge mclk_i);
      k++;
    end
    check(pix_oe_n, 1);
    check(strb_line, 5'h1f);
    repeat (20) @(negedge mclk_i);
  endtask

  task automatic t_soft_rst();
    int k;
    k = 0;
    @(posedge mclk_i);
    soft_rst <= 1'b1;
    @(posedge mclk_i);
    soft_rst <= 1'b0;
    while (pix_oe_n !== 1'b1 && k < 4) begin
      @(negedge mclk_i);
      k++;
    end
    check(pix_oe_n, 1);
    check(strb_oe_n, 1);
  endtask

  // Clock enable low freezes every flop, the interrupt drive included
  task automatic t_clk_en();
    @(posedge mclk_i);
    ce      <= 1'b0;
    irq_req <= 1'b1;
    repeat (4) @(negedge mclk_i);
    check(irq_oe_n, 1);
    check(pix_oe_n, 0);
    @(posedge mclk_i);
    ce <= 1'b1;
    repeat (2) @(negedge mclk_i);
    check(irq_oe_n, 0);
    @(posedge mclk_i);
    irq_req <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run is well under 1000 cycles
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end

  initial begin
    error_cnt  = 0;
    num_checks = 0;
    srst_i     = 1'b1;
    rst_pin_n  = 1'b1;
    addr_sel   = 1'b0;
    soft_rst   = 1'b0;
    out_en     = 1'b0;
    irq_req    = 1'b0;
    ce         = 1'b1;
    src_valid  = 1'b0;
    pol        = 4'hf;
    w_q        = '0;
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    t_reset_state();
    t_strap_irq();
    @(posedge mclk_i);
    t_fill_drain();
    @(posedge mclk_i);
    t_polarity();
    t_rst_pin();
    t_soft_rst();
    t_clk_en();
    final_report();
  end
endmodule
`default_nettype wire

// >>> bench/vdop_cap_model.sv
// Capture controller model that faces the pixel port of the output block.
// Assumes pull-ups on every strobe and the interrupt, none on pixel lines.
`timescale 1ns/1ps
`default_nettype none
module vdop_cap_model
  import vdop_pkg::*;
(
  input  wire logic             mclk_i,      // Double-rate pixel clock
  input  wire logic             clr_i,       // Clears the capture log
  input  wire logic [PIX_W-1:0] pix_i,       // Pixel lines as driven
  input  wire logic             pix_oe_n_i,  // Pixel drive enable, low
  input  wire logic [4:0]       strb_i,      // {blank, field, vsync, hsync, valid}
  input  wire logic             strb_oe_n_i, // Strobe drive enable, low
  input  wire logic             irq_i,       // Interrupt drive level
  input  wire logic             irq_oe_n_i,  // Interrupt drive enable, low
  output logic [PIX_W-1:0]      pix_line_o,  // Pixel wire level
  output logic [4:0]            strb_line_o, // Strobe wire levels
  output logic                  irq_line_o,  // Interrupt wire level
  output logic [7:0]            cap_cnt_o    // Words captured
);
  logic [PIX_W-1:0] last_pix;                // Last value seen driven
  logic [PIX_W+3:0] cap_mem [0:15];          // {blank, field, vsync, hsync, pixel}

  ////////////////////////////////////////////////////////////////////////////
  // Wire levels: a released pixel line must not show its old value, so the
  // model flips it and any late sample by the bench is caught
  always_comb begin
    pix_line_o  = pix_oe_n_i ? ~last_pix : pix_i;
    strb_line_o = strb_oe_n_i ? 5'h1f : strb_i;
    irq_line_o  = irq_oe_n_i ? 1'b1 : irq_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture on the same clock edge that launches the pins
  always_ff @(posedge mclk_i) begin
    if (clr_i) begin
      cap_cnt_o <= 8'h00;
      last_pix  <= 16'h0000;
    end else begin
      if (!pix_oe_n_i) begin
        last_pix <= pix_i;
      end
      if (!strb_oe_n_i && strb_line_o[0] === 1'b1) begin
        cap_mem[cap_cnt_o[3:0]] <= {strb_line_o[4:1], pix_line_o};
        cap_cnt_o               <= cap_cnt_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/vdop_fifo.sv
// Small synchronous FIFO for the pixel path.
// Assumes a power-free depth wrap, same-clock users, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module vdop_fifo #(
  parameter int W     = 22,                 // Word width
  parameter int DEPTH = 4                   // Number of words
) (
  input  wire logic        clk_i,           // Clock
  input  wire logic        rst_i,           // Synchronous flush, active high
  input  wire logic        ce_i,            // Clock enable
  vdop_fifo_if.fifo_mp     f                // Fill and drain sides
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;           // Storage
    logic [AW-1:0]           wp;            // Write index
    logic [AW-1:0]           rp;            // Read index
    logic [CW-1:0]           cnt;           // Words held
    logic                    rdy;           // Room for one more word
  } vdop_fifo_st_t;

  vdop_fifo_st_t q, d;
  logic push, pop;

  assign f.wr_ready = q.rdy;
  assign f.rd_valid = (q.cnt != '0);
  assign f.rd_data  = q.mem[q.rp];

  ////////////////////////////////////////////////////////////////////////
  // Next state; ready is registered so the fill side sees a flop
  always_comb begin
    d    = q;
    push = ce_i & f.wr_valid & q.rdy;
    pop  = ce_i & f.rd_ready & (q.cnt != '0);
    if (rst_i) begin
      // Flush discards any word pushed in the same cycle and clears ready, so nothing is kept in a dying buffer
      d = '0;
    end else begin
      if (push) begin
        d.mem[q.wp] = f.wr_data;
        d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : AW'(q.wp + 1'b1);
      end
      if (pop) begin
        d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : AW'(q.rp + 1'b1);
      end
      // Count moves only when exactly one side acts
      if (push && !pop) begin
        d.cnt = CW'(q.cnt + 1'b1);
      end else if (pop && !push) begin
        d.cnt = CW'(q.cnt - 1'b1);
      end
      d.rdy = (d.cnt < CW'(DEPTH));
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end
endmodule
`default_nettype wire

// >>> hw/vdop_fifo_if.sv
// Carrier between the output block and its pixel buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface vdop_fifo_if #(parameter int W = 22);
  logic         wr_valid;                   // Word offered to the buffer
  logic         wr_ready;                   // Buffer has room
  logic [W-1:0] wr_data;                    // Word written
  logic         rd_valid;                   // Buffer holds a word
  logic         rd_ready;                   // Drain side takes the word
  logic [W-1:0] rd_data;                    // Oldest word

  modport fifo_mp (
    input  wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );
  modport user_mp (
    output wr_valid, wr_data, rd_ready,
    input  wr_ready, rd_valid, rd_data
  );
endinterface
`default_nettype wire

// >>> hw/vdop_pkg.sv
// Shared constants and types for the video decoder output pin block.
// Assumes one clock (the double-rate pixel clock) and synchronous reset.
package vdop_pkg;

  // Pixel port and buffer geometry
  localparam int PIX_W      = 16;           // Pixel output lines
  localparam int FIFO_DEPTH = 4;            // Words buffered in the pixel path

  // Buffered word layout: {vblank, hblank, field, vsync, hsync, pixel, data}
  localparam int WD_DATA_LSB = 0;           // Pixel data, low bit
  localparam int WD_PIX      = 16;          // Word carries valid pixel data
  localparam int WD_HS       = 17;          // Horizontal sync interval
  localparam int WD_VS       = 18;          // Vertical sync interval
  localparam int WD_FLD      = 19;          // Field indicator
  localparam int WD_HB       = 20;          // Horizontal blanking
  localparam int WD_VB       = 21;          // Vertical blanking
  localparam int WORD_W      = 22;          // Whole buffered word

  // Reset pin: consecutive low clocks needed before the device resets
  localparam logic [2:0] RST_LOW_MIN_CYC = 3'h4;

  // Serial bus slave address (7 bits, the read/write flag excluded)
  localparam logic [6:0] ADDR_SEL_LO = 7'h44;  // Select pin low, write 88h
  localparam logic [6:0] ADDR_SEL_HI = 7'h45;  // Select pin high, write 8Ah

  // Values after reset
  localparam logic [1:0] SYNC_RST_HI = 2'h3;   // Reset pin idles high
  localparam logic [1:0] SYNC_RST_LO = 2'h0;   // Address select idles low

  // Output drive state
  typedef enum logic {
    VDOP_FLOAT,                             // All pixel and strobe pins released
    VDOP_DRIVE                              // Pins driven from the buffer
  } vdop_ostate_t;

endpackage

// >>> hw/vdop_top.sv
// Output pin logic of a video decoder: pixel port, timing strobes,
// reset pin filter, bus address strap and open-drain interrupt.
// Assumes the decoder core feeds words on the same clock, and that the
// pixel clock runs continuously; pin inputs are synchronised here.
//
// Operation
// - Pixel lines float after any reset
// - Line sync, selectable polarity, floats after reset
// - Frame sync, selectable polarity, floats after reset
// - Field output, selectable polarity, floats after reset
// - Pixel valid only on valid data cycles
// - Blank covers horizontal and vertical blanking intervals
// - Reset pin low four cycles resets device
// - Address select picks slave address 44h or 45h
// - Interrupt is open drain, low when active
`timescale 1ns/1ps
`default_nettype none
module vdop_top
  import vdop_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH          // Pixel buffer depth
) (
  input  wire logic             mclk_i,             // Double-rate pixel clock
  input  wire logic             srst_i,             // Sync reset, active high
  input  wire logic             ce_i,               // Clock enable
  // Reset and strap pins
  input  wire logic             rst_pin_n_i,        // Reset pin, active low
  input  wire logic             bus_addr_select_i,  // Address select strap
  output logic [6:0]            i2c_addr_o,         // Slave address in use
  // Configuration from the register bank
  input  wire logic             soft_rst_i,         // Software reset pulse
  input  wire logic             out_en_i,           // Drive data/timing pins
  input  wire logic             hsync_pol_i,        // 1: line sync active high
  input  wire logic             vsync_pol_i,        // 1: frame sync active high
  input  wire logic             field_pol_i,        // 1: field active high
  input  wire logic             blank_pol_i,        // 1: blank active high
  // Word stream from the decoder core
  input  wire logic             src_valid_i,        // Word offered
  output logic                  src_ready_o,        // Buffer has room
  input  wire logic [PIX_W-1:0] src_data_i,         // Pixel data
  input  wire logic             src_pix_i,          // Word holds a pixel
  input  wire logic             src_hsync_i,        // In line sync interval
  input  wire logic             src_vsync_i,        // In frame sync interval
  input  wire logic             src_field_i,        // Odd field
  input  wire logic             src_hblank_i,       // In line blanking
  input  wire logic             src_vblank_i,       // In frame blanking
  input  wire logic             irq_req_i,          // Interrupt wanted
  // Pins
  output logic [PIX_W-1:0]      pixel_out_bus_o,    // Pixel lines
  output logic                  pixel_out_oe_n_o,   // Pixel lines enable, low
  output logic                  hsync_o,            // Line sync
  output logic                  vsync_o,            // Frame sync
  output logic                  field_o,            // Field indicator
  output logic                  blank_o,            // Composite blanking
  output logic                  pixel_valid_out_o,  // Pixel valid, active high
  output logic                  strobe_oe_n_o,      // Strobe pins enable, low
  output logic                  irq_out_o,          // Interrupt level, always 0
  output logic                  irq_out_oe_n_o      // Interrupt enable, low
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    vdop_ostate_t     st;                   // Drive state
    logic [1:0]       rst_sync;             // Reset pin synchroniser
    logic [1:0]       sel_sync;             // Strap synchroniser
    logic [2:0]       low_cnt;              // Consecutive low samples
    logic             hw_rst;               // Pin reset in force
    logic [6:0]       addr;                 // Slave address
    logic [PIX_W-1:0] pix;                  // Pixel lines
    logic             pix_oe_n;             // Pixel lines released when high
    logic             hs;                   // Line sync level
    logic             vs;                   // Frame sync level
    logic             fld;                  // Field level
    logic             bl;                   // Blank level
    logic             pv;                   // Pixel valid
    logic             stb_oe_n;             // Strobes released when high
    logic             irq_oe_n;             // Interrupt pulled low when low
  } vdop_top_st_t;

  vdop_top_st_t q, d;

  // Value of every register after a bus-level reset
  localparam vdop_top_st_t ST_RST = '{
    st:       VDOP_FLOAT,
    rst_sync: SYNC_RST_HI,
    sel_sync: SYNC_RST_LO,
    low_cnt:  3'h0,
    hw_rst:   1'b0,
    addr:     ADDR_SEL_LO,
    pix:      '0,
    pix_oe_n: 1'b1,
    hs:       1'b0,
    vs:       1'b0,
    fld:      1'b0,
    bl:       1'b0,
    pv:       1'b0,
    stb_oe_n: 1'b1,
    irq_oe_n: 1'b1
  };

  // Pin level for an active condition under a polarity bit
  function automatic logic pin_lvl(input logic act, input logic pol);
    pin_lvl = ~(act ^ pol);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pixel buffer

  vdop_fifo_if #(.W(WORD_W)) fq ();

  logic             any_rst;                // Flush and release the data and timing pins
  logic             pop;                    // Word leaves the buffer
  logic [WORD_W-1:0] w;                     // Oldest word

  // Any reset empties the buffer so no stale pixels follow it
  // Pin and soft reset wait for the clock enable, like every other flop
  assign any_rst     = srst_i | (ce_i & (q.hw_rst | soft_rst_i));
  assign fq.wr_valid = src_valid_i;
  assign fq.wr_data  = {src_vblank_i, src_hblank_i, src_field_i, src_vsync_i,
                        src_hsync_i, src_pix_i, src_data_i};
  // Drain stalls while the pins float, so the buffer fills and holds the source
  assign fq.rd_ready = (q.st == VDOP_DRIVE) & ~any_rst;
  assign pop         = ce_i & fq.rd_ready & fq.rd_valid;
  assign w           = fq.rd_data;

  vdop_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i (mclk_i),
    .rst_i (any_rst),
    .ce_i  (ce_i),
    .f     (fq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    if (srst_i) begin
      d = ST_RST;
    end else if (ce_i) begin
      // Pin inputs: only the second stage is looked at
      d.rst_sync = {q.rst_sync[0], rst_pin_n_i};
      d.sel_sync = {q.sel_sync[0], bus_addr_select_i};
      d.addr     = q.sel_sync[1] ? ADDR_SEL_HI : ADDR_SEL_LO;

      // Short glitches on the reset pin are ignored by the count
      if (q.rst_sync[1]) begin
        d.low_cnt = 3'h0;
      end else if (q.low_cnt != RST_LOW_MIN_CYC) begin
        d.low_cnt = q.low_cnt + 3'h1;
      end
      d.hw_rst = (d.low_cnt == RST_LOW_MIN_CYC);

      d.irq_oe_n = ~irq_req_i;

      if (q.hw_rst || soft_rst_i) begin
        // Either reset releases every data and timing pin
        d.st       = VDOP_FLOAT;
        d.pix_oe_n = 1'b1;
        d.stb_oe_n = 1'b1;
        d.pv       = 1'b0;
      end else begin
        unique case (q.st)
          VDOP_FLOAT: begin
            // Stay released until the controller enables the outputs
            if (out_en_i) begin
              d.st       = VDOP_DRIVE;
              d.pix_oe_n = 1'b0;
              d.stb_oe_n = 1'b0;
            end
          end
          VDOP_DRIVE: begin
            if (!out_en_i) begin
              d.st       = VDOP_FLOAT;
              d.pix_oe_n = 1'b1;
              d.stb_oe_n = 1'b1;
              d.pv       = 1'b0;
            end else if (pop) begin
              // One buffered word per pixel clock, all pins together
              d.pix = w[WD_DATA_LSB +: PIX_W];
              d.pv  = w[WD_PIX];
              d.hs  = pin_lvl(w[WD_HS], hsync_pol_i);
              d.vs  = pin_lvl(w[WD_VS], vsync_pol_i);
              d.fld = pin_lvl(w[WD_FLD], field_pol_i);
              d.bl  = pin_lvl(w[WD_HB] | w[WD_VB], blank_pol_i);
            end else begin
              // Underrun: sync levels hold, but no cycle claims valid data
              d.pv = 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Single state register; clock enable already folded into d
  always_ff @(posedge mclk_i) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop except the interrupt level, tied to 0

  assign i2c_addr_o        = q.addr;
  // Buffer room flop itself, so the port agrees with what the buffer takes
  assign src_ready_o       = fq.wr_ready;
  assign pixel_out_bus_o   = q.pix;
  assign pixel_out_oe_n_o  = q.pix_oe_n;
  assign hsync_o           = q.hs;
  assign vsync_o           = q.vs;
  assign field_o           = q.fld;
  assign blank_o           = q.bl;
  assign pixel_valid_out_o = q.pv;
  assign strobe_oe_n_o     = q.stb_oe_n;
  assign irq_out_o         = 1'b0;
  assign irq_out_oe_n_o    = q.irq_oe_n;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_pix_float_rst: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && (q.hw_rst || soft_rst_i)) |=> (pixel_out_oe_n_o && !pixel_valid_out_o))
    else $error("pixel lines not released after reset");

  a_stb_float_rst: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && (q.hw_rst || soft_rst_i)) |=> strobe_oe_n_o ##1 (strobe_oe_n_o || $past(out_en_i)))
    else $error("strobes not released after reset");

  a_hsync_level: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pop && !q.hw_rst && !soft_rst_i && out_en_i)
      |=> hsync_o == ($past(w[WD_HS]) ~^ $past(hsync_pol_i)))
    else $error("line sync level or polarity wrong");

  a_vsync_level: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pop && !q.hw_rst && !soft_rst_i && out_en_i)
      |=> vsync_o == ($past(w[WD_VS]) ~^ $past(vsync_pol_i)))
    else $error("frame sync level or polarity wrong");

  a_field_level: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pop && !q.hw_rst && !soft_rst_i && out_en_i)
      |=> field_o == ($past(w[WD_FLD]) ~^ $past(field_pol_i)))
    else $error("field level or polarity wrong");

  a_valid_only_data: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(pixel_valid_out_o) |-> $past(pop) && $past(w[WD_PIX]) && !pixel_out_oe_n_o)
    else $error("pixel valid without a data word");

  a_blank_covers: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pop && !q.hw_rst && !soft_rst_i && out_en_i && (w[WD_HB] || w[WD_VB]))
      |=> blank_o == $past(blank_pol_i))
    else $error("blank not active in blanking interval");

  a_rst_four_low: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(q.hw_rst) |-> $past(!q.rst_sync[1], 1) && $past(q.low_cnt, 1) == 3'h3)
    else $error("pin reset taken before four low cycles");

  a_rst_release: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && q.rst_sync[1]) |=> !q.hw_rst)
    else $error("pin reset held after pin went high");

  a_addr_strap: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && q.sel_sync[1]) |=> (i2c_addr_o == ADDR_SEL_HI))
    else $error("slave address does not follow select pin");

  a_irq_open_drain: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i |=> (!irq_out_o && (irq_out_oe_n_o == !$past(irq_req_i))))
    else $error("interrupt pin not open drain");

  a_sync_change: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!ce_i) |=> $stable(pixel_out_bus_o) && $stable(hsync_o) && $stable(pixel_valid_out_o))
    else $error("outputs moved while clock enable low");

  // Idle side of blanking: a word outside both intervals shows the inactive level
  a_blank_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pop && out_en_i && !w[WD_HB] && !w[WD_VB])
      |=> blank_o == !$past(blank_pol_i))
    else $error("blank active outside blanking");

  a_pix_data: assert property (@(posedge mclk_i) disable iff (srst_i)
    (pop && out_en_i)
      |=> pixel_out_bus_o == $past(w[WD_DATA_LSB +: PIX_W]))
    else $error("pixel lines do not carry the popped word");

  a_addr_strap_lo: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && !q.sel_sync[1]) |=> (i2c_addr_o == ADDR_SEL_LO))
    else $error("slave address does not follow low select pin");

  // Pixel and strobe pins are released and taken back as one group
  a_oe_pair: assert property (@(posedge mclk_i) disable iff (srst_i)
    pixel_out_oe_n_o == strobe_oe_n_o)
    else $error("pixel and strobe enables differ");

  a_pv_released: assert property (@(posedge mclk_i) disable iff (srst_i)
    strobe_oe_n_o |-> !pixel_valid_out_o)
    else $error("pixel valid high while strobes released");

  // A flush must also refuse words, or stale pixels would follow the reset
  a_ready_flush: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ce_i && (q.hw_rst || soft_rst_i)) |=> !src_ready_o)
    else $error("source accepted during reset flush");

endmodule
`default_nettype wire
